// *** include/mti_pkg.sv ***
// Purpose: constants for the multiplier transfer interlock
// Assumes: one 200 MHz clock, asynchronous active-low reset
// Notes: transfer opcodes are a small local encoding fed by the decoder
package mti_pkg;
    // ========================================
    // transfer opcodes
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_STORE_MEM = 3'h1;
    localparam logic [2:0] OP_STORE_GEN = 3'h2;
    localparam logic [2:0] OP_LOAD_GEN = 3'h3;
    localparam logic [2:0] OP_LOAD_MEM = 3'h4;
    // ========================================
    // timing
    localparam int MULT_BUSY_CYCLES = 3;
    localparam logic [3:0] STORE_TAIL = 4'h1;
    localparam logic [3:0] NO_TAIL = 4'h0;
    localparam int CNT_W = 4;
endpackage

// *** logic/mti_busy_counter.sv ***
// Purpose: multiplier busy tracker
// Assumes: start pulses on the final access stage of a word multiply-accumulate
// Notes: busy lasts the configured number of cycles after the latest start; a start while busy reloads the count
`timescale 1ns/1ps
module mti_busy_counter #(
    parameter int BUSY_CYCLES = mti_pkg::MULT_BUSY_CYCLES
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic start_in,
    output logic busy_out,
    output logic last_out
);
    import mti_pkg::*;
    logic [CNT_W-1:0] cnt_q;

    // the counter is CNT_W bits wide, so longer busy spans cannot be held
    if (BUSY_CYCLES < 1 || BUSY_CYCLES > 15) begin : g_bad_busy
        $error("busy cycles out of range");
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_q <= 4'h0;
        end else if (start_in) begin
            cnt_q <= CNT_W'(BUSY_CYCLES);
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    assign busy_out = (cnt_q != 4'h0);
    assign last_out = (cnt_q == 4'h1);

    property p_busy_len;
        @(posedge clk_in) disable iff (!resetn_in)
        start_in |=> busy_out [*3] ##1 (!busy_out || $past(start_in));
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule // mti_busy_counter

// *** logic/mti_interlock.sv ***
// Purpose: stretches the access stage of accumulator transfers over a busy multiplier
// Assumes: decoder presents a transfer at execute with xfer_valid_in for one cycle
// Notes: fetch_grant_out low whenever the transfer access owns the memory path
`timescale 1ns/1ps
module mti_interlock (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic mac_final_access_in,
    input wire logic xfer_valid_in,
    input wire logic [2:0] xfer_op_in,
    input wire logic fetch_req_in,
    output logic fetch_grant_out,
    output logic access_active_out,
    output logic access_done_out,
    output logic mem_write_out,
    output logic mem_read_out,
    output logic mult_access_out,
    output logic stall_out,
    output logic multiplier_busy_out
);
    import mti_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_TAIL = 3'b100
    } mti_state_e;

    mti_state_e state_q;
    logic [2:0] op_q;
    logic [3:0] tail_q;
    logic busy;
    logic busy_last;
    logic access_req;
    logic access_fin;
    logic mem_write_q;
    logic mem_read_q;

    // ========================================
    // multiplier busy
    mti_busy_counter #(.BUSY_CYCLES(MULT_BUSY_CYCLES)) u_busy (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .start_in(mac_final_access_in),
        .busy_out(busy),
        .last_out(busy_last)
    );
    assign multiplier_busy_out = busy;

    // ========================================
    // access stage sequencing
    // every transfer except store-to-general gets an access stage
    assign access_req = xfer_valid_in && (xfer_op_in == OP_STORE_MEM || xfer_op_in == OP_LOAD_GEN ||
        xfer_op_in == OP_LOAD_MEM);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= ST_IDLE;
            op_q <= OP_NONE;
            tail_q <= NO_TAIL;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (access_req && state_q == ST_IDLE) begin
                        op_q <= xfer_op_in;
                        tail_q <= (xfer_op_in == OP_STORE_MEM) ? STORE_TAIL : NO_TAIL;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // stretched while the multiplier runs
                    if (busy_last && tail_q != NO_TAIL) begin
                        state_q <= ST_TAIL;
                    end else if (!busy || busy_last) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_TAIL: begin
                    state_q <= ST_IDLE; // one extra state for memory stores
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // loads close in the last busy cycle; a stretched store closes one state later in the tail
    assign access_fin = (state_q == ST_WAIT && (!busy || (busy_last && tail_q == NO_TAIL))) ||
        (state_q == ST_TAIL);
    assign access_active_out = (state_q != ST_IDLE);
    assign access_done_out = access_fin;
    assign mult_access_out = access_fin;
    // access owns the memory path for the whole slot, so fetch waits
    assign fetch_grant_out = fetch_req_in && (state_q == ST_IDLE);
    // younger decode and execute hold while the slot is open, except in the cycle where it closes
    assign stall_out = (state_q != ST_IDLE) && !access_fin;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_write_q <= 1'b0;
            mem_read_q <= 1'b0;
        end else begin
            mem_write_q <= (state_q != ST_IDLE) && op_q == OP_STORE_MEM;
            mem_read_q <= (state_q != ST_IDLE) && op_q == OP_LOAD_MEM;
        end
    end
    assign mem_write_out = mem_write_q;
    assign mem_read_out = mem_read_q;

    // ========================================
    // checks
    property p_fetch_block;
        @(posedge clk_in) disable iff (!resetn_in)
        access_active_out |-> !fetch_grant_out;
    endproperty
    a_fetch_block: assert property (p_fetch_block) else $error("fetch during access");

    property p_reg_fetch;
        @(posedge clk_in) disable iff (!resetn_in)
        (access_req && xfer_op_in == OP_LOAD_GEN && state_q == ST_IDLE) |=> !fetch_grant_out;
    endproperty
    a_reg_fetch: assert property (p_reg_fetch) else $error("load fetch overlap");

    property p_mem_fetch;
        @(posedge clk_in) disable iff (!resetn_in)
        (access_req && xfer_op_in == OP_LOAD_MEM && state_q == ST_IDLE) |=> !fetch_grant_out;
    endproperty
    a_mem_fetch: assert property (p_mem_fetch) else $error("memory load fetch overlap");

    property p_stretch;
        @(posedge clk_in) disable iff (!resetn_in)
        (state_q == ST_WAIT && busy && !busy_last) |-> !access_done_out;
    endproperty
    a_stretch: assert property (p_stretch) else $error("slot ended while busy");

    property p_stall;
        @(posedge clk_in) disable iff (!resetn_in)
        (access_active_out && !access_done_out) |-> stall_out;
    endproperty
    a_stall: assert property (p_stall) else $error("no stall during slot");

    property p_tail;
        @(posedge clk_in) disable iff (!resetn_in)
        (state_q == ST_WAIT && busy_last && tail_q != NO_TAIL) |=> access_done_out;
    endproperty
    a_tail: assert property (p_tail) else $error("store tail missing");

    property p_idle_end;
        @(posedge clk_in) disable iff (!resetn_in)
        (state_q == ST_WAIT && busy && !busy_last && tail_q == NO_TAIL) |-> ##[1:16] access_done_out;
    endproperty
    a_idle_end: assert property (p_idle_end) else $error("load slot never ends");

    property p_load_end;
        @(posedge clk_in) disable iff (!resetn_in)
        (state_q == ST_WAIT && busy_last && tail_q == NO_TAIL) |-> access_done_out;
    endproperty
    a_load_end: assert property (p_load_end) else $error("load slot not closed with multiplier");

    property p_store_hold;
        @(posedge clk_in) disable iff (!resetn_in)
        (state_q == ST_WAIT && busy && tail_q != NO_TAIL) |-> !access_done_out;
    endproperty
    a_store_hold: assert property (p_store_hold) else $error("store slot ended while busy");

    property p_done_close;
        @(posedge clk_in) disable iff (!resetn_in)
        access_done_out |=> !access_active_out;
    endproperty
    a_done_close: assert property (p_done_close) else $error("slot open after done");

    property p_grant_free;
        @(posedge clk_in) disable iff (!resetn_in)
        (!access_active_out && fetch_req_in) |-> fetch_grant_out;
    endproperty
    a_grant_free: assert property (p_grant_free) else $error("fetch refused with no access");

    property p_store_fetch;
        @(posedge clk_in) disable iff (!resetn_in)
        (access_req && xfer_op_in == OP_STORE_MEM && state_q == ST_IDLE) |=> !fetch_grant_out;
    endproperty
    a_store_fetch: assert property (p_store_fetch) else $error("store fetch overlap");

    property p_rw_excl;
        @(posedge clk_in) disable iff (!resetn_in)
        mem_write_out |-> !mem_read_out;
    endproperty
    a_rw_excl: assert property (p_rw_excl) else $error("read and write together");

    property p_busy_rise;
        @(posedge clk_in) disable iff (!resetn_in)
        mac_final_access_in |=> multiplier_busy_out;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy missing after final access");

    property p_stall_free;
        @(posedge clk_in) disable iff (!resetn_in)
        !access_active_out |-> !stall_out;
    endproperty
    a_stall_free: assert property (p_stall_free) else $error("stall with no slot open");

    property p_start;
        @(posedge clk_in) disable iff (!resetn_in)
        (access_req && state_q == ST_IDLE) |=> access_active_out;
    endproperty
    a_start: assert property (p_start) else $error("no access stage added");

    property p_write;
        @(posedge clk_in) disable iff (!resetn_in)
        (access_active_out && op_q == OP_STORE_MEM) |=> mem_write_out;
    endproperty
    a_write: assert property (p_write) else $error("store not written");

    property p_read;
        @(posedge clk_in) disable iff (!resetn_in)
        (access_active_out && op_q == OP_LOAD_MEM) |=> mem_read_out;
    endproperty
    a_read: assert property (p_read) else $error("load not read");
endmodule // mti_interlock

// *** tb/multiplier_transfer_interlock_tb.sv ***
// Purpose: self-checking bench for the accumulator transfer interlock
// Assumes: busy lasts MULT_BUSY_CYCLES (3) after the final multiply-accumulate access
// Notes: outputs are sampled at the falling edge, where they have settled
`timescale 1ns/1ps
module multiplier_transfer_interlock_tb;
    import mti_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic mac = 1'b0;
    logic valid = 1'b0;
    logic [2:0] xop = OP_NONE;
    logic fetch = 1'b0;
    logic grant, act, done, wr, rd, macc, stall, busy;
    int fails = 0;
    int n_checks = 0;
    always #2.5 clk_in = ~clk_in;
    mti_interlock dut (.clk_in(clk_in), .resetn_in(resetn_in), .mac_final_access_in(mac),
        .xfer_valid_in(valid), .xfer_op_in(xop), .fetch_req_in(fetch), .fetch_grant_out(grant),
        .access_active_out(act), .access_done_out(done), .mem_write_out(wr), .mem_read_out(rd),
        .mult_access_out(macc), .stall_out(stall), .multiplier_busy_out(busy));
    // ====================
    // checking
    task automatic chk(input string nm, input logic e, input logic s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", nm, e, s);
        end
    endtask
    // one cycle: judge at the falling edge, return on the next rising edge for the caller to drive
    task automatic cyc(input logic a, input logic d, input logic b, input logic w, input logic r);
        @(negedge clk_in);
        chk("active", a, act);
        chk("done", d, done);
        chk("mult_access", d, macc);
        chk("stall", a & ~d, stall);
        chk("fetch_grant", fetch & ~a, grant);
        chk("busy", b, busy);
        chk("mem_write", w, wr);
        chk("mem_read", r, rd);
        @(posedge clk_in);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ====================
    // scenarios
    task automatic t_store_busy();
        mac <= 1'b1;
        fetch <= 1'b1;
        cyc(0, 0, 0, 0, 0);
        mac <= 1'b0;
        valid <= 1'b1;
        xop <= OP_STORE_MEM;
        cyc(0, 0, 1, 0, 0);
        valid <= 1'b0;
        cyc(1, 0, 1, 0, 0);
        cyc(1, 0, 1, 1, 0);
        cyc(1, 1, 0, 1, 0);
        cyc(0, 0, 0, 1, 0);
        cyc(0, 0, 0, 0, 0);
    endtask
    // a second request held into the open slot must be dropped
    task automatic t_load_busy(input logic [2:0] op);
        logic m;
        m = (op == OP_LOAD_MEM);
        mac <= 1'b1;
        fetch <= 1'b1;
        cyc(0, 0, 0, 0, 0);
        mac <= 1'b0;
        valid <= 1'b1;
        xop <= op;
        cyc(0, 0, 1, 0, 0);
        cyc(1, 0, 1, 0, 0);
        valid <= 1'b0;
        cyc(1, 1, 1, 0, m);
        cyc(0, 0, 0, 0, m);
        cyc(0, 0, 0, 0, 0);
    endtask
    task automatic t_idle(input logic [2:0] op);
        logic a;
        logic w;
        a = (op == OP_STORE_MEM) || (op == OP_LOAD_GEN) || (op == OP_LOAD_MEM);
        w = (op == OP_STORE_MEM);
        valid <= 1'b1;
        xop <= op;
        fetch <= 1'b0;
        cyc(0, 0, 0, 0, 0);
        valid <= 1'b0;
        cyc(a, a, 0, 0, 0);
        cyc(0, 0, 0, w, op == OP_LOAD_MEM);
        cyc(0, 0, 0, 0, 0);
    endtask
    // ====================
    // main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        t_store_busy();
        t_load_busy(OP_LOAD_GEN);
        t_load_busy(OP_LOAD_MEM);
        t_idle(OP_NONE);
        t_idle(OP_STORE_GEN);
        t_idle(OP_LOAD_GEN);
        t_idle(OP_LOAD_MEM);
        t_idle(OP_STORE_MEM);
        give_verdict();
    end
    // the sequence needs well under 100 cycles; 2000 leaves ample margin
    initial begin
        #10000;
        fails++;
        give_verdict();
    end
endmodule // multiplier_transfer_interlock_tb
